// File: pmic_pkg.sv
// Shared types and constants of the power control state machine.
// Assumes a single 20 MHz core clock; slow-clock timing arrives as a tick made on it from the synchronised 32 kHz pin.
package pmic_pkg;

    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned INIT_TIME_US = 8000;
    localparam int unsigned INIT_CYCLES = (INIT_TIME_US * (CLK_HZ / 1000000) + 0) ;
    localparam int unsigned SLOW_SYNC_DEPTH = 3;
    localparam logic [15:0] TIMER_RESET_VALUE = 16'h0000;
    localparam int unsigned NUM_BUCKS = 6;

    typedef enum logic [9:0] {
        ST_COIN_CELL  = 10'h001,
        ST_OFF        = 10'h002,
        ST_COLD_START = 10'h004,
        ST_WATCHDOG   = 10'h008,
        ST_ON         = 10'h010,
        ST_UOFF_WAIT  = 10'h020,
        ST_MEMHOLD    = 10'h040,
        ST_USER_OFF   = 10'h080,
        ST_WARM_START = 10'h100,
        ST_POWER_CUT  = 10'h200
    } pwr_state_t;

    typedef struct packed {
        logic warm_start_enable;
        logic keep_clock_mode;
        logic cpu_clock_out_enable;
        logic useroff_clock_keep;
        logic watchdog_restart_select;
        logic power_cut_enable;
        logic [NUM_BUCKS-1:0] buck_memhold_mode;
        logic [NUM_BUCKS-1:0] buck_useroff_mode;
    } pwr_cfg_t;

    typedef struct packed {
        logic [15:0] reset_time;
        logic [15:0] watchdog_time;
        logic [15:0] wait_time;
        logic [15:0] power_cut_time;
    } pwr_times_t;

endpackage

// File: slow_timer.sv
// Down counter advanced by the 32 kHz tick.
// Assumes tick_i is a one-cycle pulse on clk_i from synchronised slow clock edges.
`timescale 1ns/1ns
module slow_timer
    import pmic_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [15:0] preset_i,
    input wire logic tick_i,
    output logic expired_o
);

    typedef struct packed {
        logic [15:0] count;
        logic running;
        logic expired;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.expired = 1'b0;
        if (start_i)
        begin
            s_d.count = preset_i;
            s_d.running = 1'b1;
        end
        else if (s_q.running && tick_i)
        begin
            if (s_q.count == TIMER_RESET_VALUE)
            begin
                s_d.running = 1'b0;
                s_d.expired = 1'b1;
            end
            else
            begin
                s_d.count = s_q.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign expired_o = s_q.expired;

endmodule

// File: pmic_power_state_machine.sv
// Power control state machine: state sequencing, reset and slow clock gating, buck retention.
// Assumes the supply comparators, turn-on detect and 32 kHz clock arrive as asynchronous pins.
`timescale 1ns/1ns
// Contract
// RULE_01 - Coin cell ignores turn-on; goes off once always-on supply exceeds threshold. The code stays in coin cell while the backup cell is low.
// RULE_02 - Coin cell and off hold both reset outputs low.
// RULE_03 - Backup cell collapse in coin cell forces full reset of all bits.
// RULE_04 - Off exits only on valid turn-on, refused under undervoltage. The code also leaves off for coin cell when the supply drops.
// RULE_05 - Cold start from off turn-on, warm boot, cut recovery or watchdog restart.
// RULE_06 - Cold or warm start first spends init interval, then regulators sequence.
// RULE_07 - Reset timer in cold start; resets low; expiry to watchdog, resets high.
// RULE_08 - Cold start and watchdog states ignore watchdog and standby inputs.
// RULE_09 - Watchdog timer in watchdog state; resets high; expiry to on.
// RULE_10 - Processor keeps watchdog input high in on; low leaves on.
// RULE_11 - User off request bit enters user off wait; watchdog input ignored.
// RULE_12 - Wait timer expiry goes user off with warm enable, else memory hold.
// RULE_13 - User off request bit clears when system reset falls leaving wait.
// RULE_14 - Memory hold and user off exit only on turn-on; linear regulators off.
// RULE_15 - Memory hold: resets low, clocks off, cpu clock kept by keep clock mode.
// RULE_16 - Memory hold keeps bucks whose memhold bit is one, others off.
// RULE_17 - Turn-on in memory hold enters cold start, loads defaults, flags wake irq.
// RULE_18 - Retained bucks stay on leaving low power state, defaults reapplied later.
// RULE_19 - User off: system reset low, cpu reset high, peripheral clock off.
// RULE_20 - User off cpu clock kept if enable and keep bits, or keep clock mode.
// RULE_21 - User off keeps bucks whose useroff bit is one, others off.
// RULE_22 - User off turn-on enters warm start; expiry to watchdog, warm irq, release.
// RULE_23 - All timers count the 32 kHz clock with parameterised durations; the init interval counts core clock cycles instead.
// RULE_24 - Power cut shuts everything, resets asserted; supply return to cold start, expiry to off.
// RULE_25 - Watchdog fall in on: restart select one cold start, zero off.
// RULE_26 - Register control only in watchdog, on, wait; interrupt low elsewhere.
// RULE_27 - Power cut expiry clears cut flag, pulses shutdown low one slow cycle.
module pmic_power_state_machine
    import pmic_pkg::*;
#(
    parameter int unsigned INIT_COUNT = INIT_CYCLES
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic slow_clock_i,
    input wire logic supply_ok_i,
    input wire logic backup_cell_ok_i,
    input wire logic turn_on_i,
    input wire logic watchdog_input_i,
    input wire logic standby_i,
    input wire logic user_off_set_i,
    input wire logic cut_expiry_set_i,
    input wire pwr_cfg_t cfg_i,
    input wire pwr_times_t times_i,
    input wire logic irq_request_i,
    output logic system_reset_out_n_o,
    output logic cpu_reset_out_n_o,
    output logic periph_slow_clock_en_o,
    output logic cpu_slow_clock_en_o,
    output logic [NUM_BUCKS-1:0] buck_enable_o,
    output logic [NUM_BUCKS-1:0] buck_low_power_o,
    output logic linear_enable_o,
    output logic sequencer_start_o,
    output logic load_defaults_o,
    output logic full_reset_o,
    output logic register_access_ok_o,
    output logic irq_line_o,
    output logic user_off_request_bit_o,
    output logic cut_expiry_flag_o,
    output logic shutdown_pulse_n_o,
    output logic memhold_wake_irq_o,
    output logic warm_start_irq_o,
    output logic watchdog_restart_irq_o,
    output logic [9:0] state_o
);

    typedef struct packed {
        pwr_state_t st;
        logic [2:0] sync_slow;
        logic [2:0] sync_supply;
        logic [2:0] sync_cell;
        logic [2:0] sync_on;
        logic [2:0] sync_wdi;
        logic slow_f;
        logic supply_f;
        logic cell_f;
        logic on_f;
        logic wdi_f;
        logic [17:0] init_cnt;
        logic init_done;
        logic uoff_req;
        logic cut_flag;
        logic shut_n;
        logic shut_arm;
        logic sys_rst_n;
        logic cpu_rst_n;
        logic pclk_en;
        logic cclk_en;
        logic [NUM_BUCKS-1:0] buck_en;
        logic [NUM_BUCKS-1:0] buck_lp;
        logic lin_en;
        logic seq_start;
        logic load_def;
        logic full_rst;
        logic mh_irq;
        logic warm_irq;
        logic wdr_irq;
        logic reg_ok;
        logic irq;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;

    logic tick;
    logic start_reset;
    logic start_wd;
    logic start_wait;
    logic start_cut;
    logic reset_exp;
    logic wd_exp;
    logic wait_exp;
    logic cut_exp;

    // A change counts only once the last two stages agree, so a metastable first stage is never read.
    function automatic logic filt(input logic [2:0] sync, input logic prev);
        filt = (sync[1] == sync[2]) ? sync[2] : prev;
    endfunction

    // The tick is taken from registered stages only, so it never feeds back through the next-state copy.
    assign tick = filt(s_q.sync_slow, s_q.slow_f) && !s_q.slow_f;
    assign start_reset = (s_d.st == ST_COLD_START || s_d.st == ST_WARM_START) && s_d.st != s_q.st;
    assign start_wd = s_d.st == ST_WATCHDOG && s_q.st != ST_WATCHDOG;
    assign start_wait = s_d.st == ST_UOFF_WAIT && s_q.st != ST_UOFF_WAIT;
    assign start_cut = s_d.st == ST_POWER_CUT && s_q.st != ST_POWER_CUT;

    // Every timer shares the slow tick so durations are in 32 kHz cycles.
    slow_timer u_reset_timer (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_reset),
        .preset_i(times_i.reset_time), .tick_i(tick), .expired_o(reset_exp)); // RULE_23
    slow_timer u_wd_timer (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_wd),
        .preset_i(times_i.watchdog_time), .tick_i(tick), .expired_o(wd_exp)); // RULE_23
    slow_timer u_wait_timer (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_wait),
        .preset_i(times_i.wait_time), .tick_i(tick), .expired_o(wait_exp)); // RULE_23
    slow_timer u_cut_timer (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_cut),
        .preset_i(times_i.power_cut_time), .tick_i(tick), .expired_o(cut_exp)); // RULE_23

    always_comb
    begin
        s_d = s_q;
        s_d.sync_slow = {s_q.sync_slow[1:0], slow_clock_i};
        s_d.sync_supply = {s_q.sync_supply[1:0], supply_ok_i};
        s_d.sync_cell = {s_q.sync_cell[1:0], backup_cell_ok_i};
        s_d.sync_on = {s_q.sync_on[1:0], turn_on_i};
        s_d.sync_wdi = {s_q.sync_wdi[1:0], watchdog_input_i};
        s_d.slow_f = filt(s_q.sync_slow, s_q.slow_f);
        s_d.supply_f = filt(s_q.sync_supply, s_q.supply_f);
        s_d.cell_f = filt(s_q.sync_cell, s_q.cell_f);
        s_d.on_f = filt(s_q.sync_on, s_q.on_f);
        s_d.wdi_f = filt(s_q.sync_wdi, s_q.wdi_f);
        s_d.seq_start = 1'b0;
        s_d.load_def = 1'b0;
        s_d.full_rst = 1'b0;
        s_d.mh_irq = 1'b0;
        s_d.warm_irq = 1'b0;
        s_d.wdr_irq = 1'b0;
        if (user_off_set_i)
        begin
            s_d.uoff_req = 1'b1;
        end
        if (cut_expiry_set_i)
        begin
            s_d.cut_flag = 1'b1;
        end
        if (tick)
        begin
            s_d.shut_n = !s_q.shut_arm;
            s_d.shut_arm = 1'b0;
        end
        // Initialisation runs before the sequencer is told to bring regulators up.
        if (s_q.init_cnt != 18'h00000)
        begin
            s_d.init_cnt = s_q.init_cnt - 18'h00001; // RULE_06
            if (s_q.init_cnt == 18'h00001)
            begin
                s_d.init_done = 1'b1;
                s_d.seq_start = 1'b1; // RULE_06
            end
        end
        unique case (s_q.st)
            ST_COIN_CELL:
            begin
                if (!s_q.cell_f)
                begin
                    s_d.full_rst = 1'b1; // RULE_03
                end
                else if (s_q.supply_f)
                begin
                    s_d.st = ST_OFF; // RULE_01
                end
            end
            ST_OFF:
            begin
                if (!s_q.supply_f)
                begin
                    s_d.st = ST_COIN_CELL;
                end
                else if (s_q.on_f)
                begin
                    s_d.st = ST_COLD_START; // RULE_04 RULE_05
                end
            end
            ST_COLD_START, ST_WARM_START:
            begin
                // Watchdog and standby inputs are deliberately not consulted here.
                if (reset_exp)
                begin
                    s_d.st = ST_WATCHDOG; // RULE_07 RULE_08
                    s_d.warm_irq = s_q.st == ST_WARM_START; // RULE_22
                end
            end
            ST_WATCHDOG:
            begin
                if (wd_exp)
                begin
                    s_d.st = ST_ON; // RULE_09 RULE_08
                end
            end
            ST_ON:
            begin
                if (s_q.uoff_req)
                begin
                    s_d.st = ST_UOFF_WAIT; // RULE_11
                end
                else if (!s_q.wdi_f)
                begin
                    s_d.st = cfg_i.watchdog_restart_select ? ST_COLD_START : ST_OFF; // RULE_10 RULE_25
                    s_d.wdr_irq = cfg_i.watchdog_restart_select; // RULE_05
                end
            end
            ST_UOFF_WAIT:
            begin
                if (wait_exp)
                begin
                    s_d.st = cfg_i.warm_start_enable ? ST_USER_OFF : ST_MEMHOLD; // RULE_12
                    s_d.uoff_req = 1'b0; // RULE_13
                end
            end
            ST_MEMHOLD:
            begin
                if (s_q.on_f)
                begin
                    s_d.st = ST_COLD_START; // RULE_14 RULE_17
                    s_d.load_def = 1'b1; // RULE_17
                    s_d.mh_irq = 1'b1; // RULE_17
                end
            end
            ST_USER_OFF:
            begin
                if (s_q.on_f)
                begin
                    s_d.st = ST_WARM_START; // RULE_14 RULE_22
                    s_d.load_def = 1'b1;
                end
            end
            ST_POWER_CUT:
            begin
                if (s_q.supply_f)
                begin
                    s_d.st = ST_COLD_START; // RULE_24 RULE_05
                end
                else if (cut_exp)
                begin
                    s_d.st = ST_OFF; // RULE_24
                    s_d.cut_flag = 1'b0; // RULE_27
                    s_d.shut_arm = 1'b1; // RULE_27
                end
            end
            default:
            begin
                s_d.st = ST_OFF;
            end
        endcase
        // A supply collapse while powered drops into a cut, or straight off when cuts are disabled.
        if (!s_q.supply_f && (s_q.st & (ST_COLD_START | ST_WATCHDOG | ST_ON | ST_UOFF_WAIT | ST_WARM_START)) != '0)
        begin
            s_d.st = cfg_i.power_cut_enable ? ST_POWER_CUT : ST_OFF;
        end
        if ((s_d.st == ST_COLD_START || s_d.st == ST_WARM_START) && s_d.st != s_q.st)
        begin
            s_d.init_cnt = INIT_COUNT[17:0]; // RULE_06
            s_d.init_done = 1'b0;
        end
        s_d.sys_rst_n = s_d.st == ST_WATCHDOG || s_d.st == ST_ON || s_d.st == ST_UOFF_WAIT; // RULE_02 RULE_07 RULE_15
        s_d.cpu_rst_n = s_d.sys_rst_n || s_d.st == ST_USER_OFF || s_d.st == ST_WARM_START; // RULE_19 RULE_22 RULE_24
        s_d.reg_ok = s_d.sys_rst_n; // RULE_26
        s_d.irq = irq_request_i && (s_d.st == ST_WATCHDOG || s_d.st == ST_ON); // RULE_26
        s_d.pclk_en = s_d.sys_rst_n; // RULE_15 RULE_19
        unique case (s_d.st)
            ST_MEMHOLD:
            begin
                s_d.cclk_en = cfg_i.keep_clock_mode; // RULE_15
            end
            ST_USER_OFF, ST_WARM_START:
            begin
                s_d.cclk_en = (cfg_i.cpu_clock_out_enable && cfg_i.useroff_clock_keep) || cfg_i.keep_clock_mode; // RULE_20
            end
            default:
            begin
                s_d.cclk_en = s_d.sys_rst_n;
            end
        endcase
        s_d.lin_en = (s_d.st & (ST_WATCHDOG | ST_ON | ST_UOFF_WAIT)) != '0 ||
            ((s_d.st == ST_COLD_START || s_d.st == ST_WARM_START) && s_d.init_done); // RULE_14
        for (int b = 0; b < NUM_BUCKS; b++)
        begin
            unique case (s_d.st)
                ST_MEMHOLD:
                begin
                    s_d.buck_en[b] = cfg_i.buck_memhold_mode[b]; // RULE_16
                    s_d.buck_lp[b] = cfg_i.buck_memhold_mode[b]; // RULE_16
                end
                ST_USER_OFF:
                begin
                    s_d.buck_en[b] = cfg_i.buck_useroff_mode[b]; // RULE_21
                    s_d.buck_lp[b] = cfg_i.buck_useroff_mode[b]; // RULE_21
                end
                ST_COLD_START, ST_WARM_START:
                begin
                    // Retained bucks stay up; the sequencer later restores their default settings.
                    s_d.buck_en[b] = s_q.buck_en[b] || s_d.init_done; // RULE_18
                    s_d.buck_lp[b] = s_q.buck_lp[b] && !s_d.init_done; // RULE_18
                end
                ST_WATCHDOG, ST_ON, ST_UOFF_WAIT:
                begin
                    s_d.buck_en[b] = 1'b1;
                    s_d.buck_lp[b] = 1'b0;
                end
                default:
                begin
                    s_d.buck_en[b] = 1'b0; // RULE_24
                    s_d.buck_lp[b] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_q <= '0;
            s_q.st <= ST_COIN_CELL;
            s_q.shut_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign system_reset_out_n_o = s_q.sys_rst_n;
    assign cpu_reset_out_n_o = s_q.cpu_rst_n;
    assign periph_slow_clock_en_o = s_q.pclk_en;
    assign cpu_slow_clock_en_o = s_q.cclk_en;
    assign buck_enable_o = s_q.buck_en;
    assign buck_low_power_o = s_q.buck_lp;
    assign linear_enable_o = s_q.lin_en;
    assign sequencer_start_o = s_q.seq_start;
    assign load_defaults_o = s_q.load_def;
    assign full_reset_o = s_q.full_rst;
    assign register_access_ok_o = s_q.reg_ok;
    assign irq_line_o = s_q.irq;
    assign user_off_request_bit_o = s_q.uoff_req;
    assign cut_expiry_flag_o = s_q.cut_flag;
    assign shutdown_pulse_n_o = s_q.shut_n;
    assign memhold_wake_irq_o = s_q.mh_irq;
    assign warm_start_irq_o = s_q.warm_irq;
    assign watchdog_restart_irq_o = s_q.wdr_irq;
    assign state_o = s_q.st;

    AST_OFF_RESETS: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_02
        (s_q.st == ST_OFF || s_q.st == ST_COIN_CELL) |=> !system_reset_out_n_o && !cpu_reset_out_n_o)
        else $error("Reset released in off or coin cell.");
    AST_COIN_NO_TURN_ON: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_01
        s_q.st == ST_COIN_CELL && !s_q.supply_f |=> s_q.st == ST_COIN_CELL)
        else $error("Coin cell left without supply.");
    AST_OFF_UV: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_04
        s_q.st == ST_OFF && !s_q.supply_f |=> s_q.st != ST_COLD_START)
        else $error("Turn-on accepted under undervoltage.");
    AST_COLD_RELEASE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_07
        s_q.st == ST_COLD_START && reset_exp && s_q.supply_f |=> s_q.st == ST_WATCHDOG ##1 system_reset_out_n_o)
        else $error("Cold start expiry did not release resets.");
    AST_WD_RESTART: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_25
        s_q.st == ST_ON && !s_q.uoff_req && !s_q.wdi_f && s_q.supply_f
        |=> s_q.st == (cfg_i.watchdog_restart_select ? ST_COLD_START : ST_OFF))
        else $error("Wrong target on watchdog fall.");
    AST_WAIT_EXIT: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_12
        s_q.st == ST_UOFF_WAIT && wait_exp && s_q.supply_f
        |=> s_q.st == ($past(cfg_i.warm_start_enable) ? ST_USER_OFF : ST_MEMHOLD) && !s_q.uoff_req)
        else $error("Wait exit wrong.");
    AST_USER_OFF_RESETS: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_19
        s_q.st == ST_USER_OFF |=> ##1 (!system_reset_out_n_o && cpu_reset_out_n_o) || s_q.st != ST_USER_OFF)
        else $error("User off reset levels wrong.");
    AST_MEMHOLD_WAKE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_17
        s_q.st == ST_MEMHOLD && s_q.on_f |=> s_q.st == ST_COLD_START && memhold_wake_irq_o)
        else $error("Memory hold wake missing.");
    AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_26
        irq_line_o |-> s_q.st == ST_WATCHDOG || s_q.st == ST_ON)
        else $error("Interrupt outside watchdog and on.");
    AST_SHUTDOWN: assert property (@(posedge clk_i) disable iff (!nrst_i) // RULE_27
        s_q.st == ST_POWER_CUT && cut_exp && !s_q.supply_f |=> !cut_expiry_flag_o && s_q.shut_arm)
        else $error("Cut expiry handling wrong.");

endmodule

// File: cpu_model.sv
// Processor model: watchdog keep-alive level and user off request pulse.
// Assumes the bench commands a watchdog drop or an off request by level.
`timescale 1ns/1ns
module cpu_model
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic drop_i,
    input wire logic off_req_i,
    output logic watchdog_input_o,
    output logic user_off_set_o
);
    logic req_q;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            req_q <= 1'b0;
            watchdog_input_o <= 1'b1;
            user_off_set_o <= 1'b0;
        end
        else
        begin
            watchdog_input_o <= !drop_i;
            user_off_set_o <= off_req_i && !req_q;
            req_q <= off_req_i;
        end
    end
endmodule

// File: tb.sv
// Bench of the power state machine: walks the power states other than power cut through its pins.
// Assumes the slow clock is made here at about 32 kHz and timer presets are small.
`timescale 1ns/1ns
module tb;
    import pmic_pkg::*;
    logic clk_i = 1'b0, nrst_i = 1'b0, slow_clock_i = 1'b0, supply_ok_i = 1'b0, turn_on_i = 1'b0;
    logic drop = 1'b0, off_req = 1'b0, watchdog_input, uoff_set, sys_n, cpu_n, pclk, cclk, acc, uoff_bit;
    logic cell_ok = 1'b1, frst, irq, mhw, wsi, wri;
    logic [5:0] bucks;
    logic [9:0] state;
    pwr_cfg_t cfg = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 6'h08, 6'h0b};
    pwr_times_t times = '{16'h0001, 16'h0001, 16'h0002, 16'h0001};
    int bad_count = 0, comparisons = 0, slow_cnt = 0;
    always #25 clk_i = !clk_i;
    // One toggle every 312 cycles keeps the tick near 32 kHz without a second timescale.
    always @(posedge clk_i)
    begin
        slow_cnt <= (slow_cnt == 311) ? 0 : slow_cnt + 1;
        if (slow_cnt == 311)
            slow_clock_i <= !slow_clock_i;
    end
    cpu_model cpu_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .drop_i(drop), .off_req_i(off_req),
        .watchdog_input_o(watchdog_input), .user_off_set_o(uoff_set));
    pmic_power_state_machine #(.INIT_COUNT(20)) pmic_power_state_machine_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .slow_clock_i(slow_clock_i), .supply_ok_i(supply_ok_i), .backup_cell_ok_i(cell_ok), .turn_on_i(turn_on_i),
        .watchdog_input_i(watchdog_input), .standby_i(1'b0), .user_off_set_i(uoff_set), .cut_expiry_set_i(1'b0),
        .cfg_i(cfg), .times_i(times), .irq_request_i(1'b1), .system_reset_out_n_o(sys_n),
        .cpu_reset_out_n_o(cpu_n), .periph_slow_clock_en_o(pclk), .cpu_slow_clock_en_o(cclk),
        .buck_enable_o(bucks), .buck_low_power_o(), .linear_enable_o(), .sequencer_start_o(),
        .load_defaults_o(), .full_reset_o(frst), .register_access_ok_o(acc), .irq_line_o(irq),
        .user_off_request_bit_o(uoff_bit), .cut_expiry_flag_o(), .shutdown_pulse_n_o(),
        .memhold_wake_irq_o(mhw), .warm_start_irq_o(wsi), .watchdog_restart_irq_o(wri), .state_o(state));
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_state(input pwr_state_t st);
        int n;
        n = 0;
        while (state !== st && n < 8000)
        begin
            @(negedge clk_i);
            n++;
        end
        check("state", state, st);
        if (state !== st)
            conclude();
    endtask
    task automatic press();
        @(posedge clk_i);
        turn_on_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        turn_on_i <= 1'b0;
    endtask
    task automatic request_off(input logic warm);
        @(posedge clk_i);
        cfg.warm_start_enable <= warm;
        off_req <= 1'b1;
        @(posedge clk_i);
        off_req <= 1'b0;
        wait_state(ST_UOFF_WAIT);
        check("request bit", uoff_bit, 1'b1);
        drop <= 1'b1;
    endtask
    task automatic t_coin();
        check("resets", {sys_n, cpu_n}, 2'b00);
        cell_ok <= 1'b0;
        repeat (10) @(negedge clk_i);
        check("full reset", frst, 1'b1);
        cell_ok <= 1'b1;
        press();
        repeat (20) @(negedge clk_i);
        check("coin", state, ST_COIN_CELL);
        supply_ok_i <= 1'b1;
        wait_state(ST_OFF);
        repeat (20) @(negedge clk_i);
        check("off", state, ST_OFF);
        check("resets", {sys_n, cpu_n}, 2'b00);
    endtask
    task automatic run_up();
        drop <= 1'b1;
        check("resets", {sys_n, cpu_n}, 2'b00);
        wait_state(ST_WATCHDOG);
        check("resets", {sys_n, cpu_n}, 2'b11);
        drop <= 1'b0;
        wait_state(ST_ON);
        repeat (50) @(negedge clk_i);
        check("on", state, ST_ON);
        check("access", acc, 1'b1);
        check("irq", irq, 1'b1);
    endtask
    task automatic t_boot();
        press();
        wait_state(ST_COLD_START);
        run_up();
    endtask
    task automatic t_wdog(input logic sel);
        cfg.watchdog_restart_select <= sel;
        drop <= 1'b1;
        wait_state(sel ? ST_COLD_START : ST_OFF);
        check("restart irq", wri, sel);
    endtask
    task automatic t_memhold();
        request_off(1'b0);
        wait_state(ST_MEMHOLD);
        drop <= 1'b0;
        check("resets", {sys_n, cpu_n}, 2'b00);
        check("clocks", {pclk, cclk}, 2'b00);
        check("bucks", bucks, 6'h08);
        check("access", acc, 1'b0);
        check("request bit", uoff_bit, 1'b0);
        check("irq", irq, 1'b0);
        turn_on_i <= 1'b1;
        wait_state(ST_COLD_START);
        check("wake irq", mhw, 1'b1);
        turn_on_i <= 1'b0;
        run_up();
    endtask
    task automatic t_useroff();
        request_off(1'b1);
        wait_state(ST_USER_OFF);
        drop <= 1'b0;
        check("resets", {sys_n, cpu_n}, 2'b01);
        check("clocks", {pclk, cclk}, 2'b01);
        check("bucks", bucks, 6'h0b);
        press();
        wait_state(ST_WARM_START);
        check("resets", {sys_n, cpu_n}, 2'b01);
        wait_state(ST_WATCHDOG);
        check("warm irq", wsi, 1'b1);
        check("resets", {sys_n, cpu_n}, 2'b11);
        wait_state(ST_ON);
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        t_coin();
        t_boot();
        t_wdog(1'b1);
        run_up();
        t_memhold();
        t_useroff();
        t_wdog(1'b0);
        conclude();
    end
endmodule
